// ===== verilog/lci_pkg.sv
// Package of the load command interpreter: register map, opcodes,
// error codes, limits in percent and the carrier structs.
// Assumes one 10 MHz clock and AHB-Lite word access.
`default_nettype none
package lci_pkg;
  // Register byte offsets
  localparam logic [7:0]  ADDR_CMD    = 8'h00;
  localparam logic [7:0]  ADDR_PARAM  = 8'h04;
  localparam logic [7:0]  ADDR_CFG    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0C;
  localparam logic [7:0]  ADDR_RES0   = 8'h20;
  // Error queue depth and codes (16-bit two's complement)
  localparam int          ERRQ_DEPTH  = 5;
  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [15:0] ERR_CMD     = 16'hFF9C;
  localparam logic [15:0] ERR_EXEC    = 16'hFF38;
  localparam logic [15:0] ERR_LOCAL   = 16'hFF37;
  localparam logic [15:0] ERR_RANGE   = 16'hFF22;
  // Operation enable filter
  localparam logic [15:0] OPER_EN_LO  = 16'h0100;
  localparam logic [15:0] OPER_EN_HI  = 16'h0F00;
  localparam logic [15:0] OPER_EN_RST = 16'h0F00;
  // Scaling
  localparam int          PCT_SET     = 102;
  localparam int          PCT_MEAS    = 125;
  localparam int          PCT_DEN     = 100;
  localparam int          KILO        = 1000;
  localparam int          R_SCALE     = 1000;

  typedef enum logic [4:0] {
    OP_NOP   = 5'h00, OP_SET_V = 5'h01, OP_SET_I = 5'h02, OP_SET_P = 5'h03,
    OP_SET_R = 5'h04, OP_Q_V   = 5'h05, OP_Q_I   = 5'h06, OP_Q_P   = 5'h07,
    OP_Q_R   = 5'h08, OP_MEAS_V = 5'h09, OP_MEAS_I = 5'h0A, OP_MEAS_P = 5'h0B,
    OP_COMBINED_MEASUREMENT_QUERY = 5'h0C, OP_LOCK = 5'h0D, OP_Q_OWNER = 5'h0E, OP_INPUT = 5'h0F,
    OP_Q_INPUT = 5'h10, OP_ERR_NEXT = 5'h11, OP_ERR_ALL = 5'h12, OP_CLS = 5'h13,
    OP_OPER_EN = 5'h14, OP_Q_OPER_EN = 5'h15
  } lci_op_t;
  typedef enum logic [1:0] {KW_NUM = 2'b00, KW_MIN = 2'b01, KW_MAX = 2'b10} lci_kw_t;
  typedef enum logic [1:0] {OWN_NONE = 2'b00, OWN_REMOTE = 2'b01,
                            OWN_LOCAL = 2'b10} lci_own_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_CAP = 1'b1} lci_st_t;

  // Command word, low ten bits of the CMD register
  typedef struct packed {
    logic [1:0] ifId;
    logic       kilo;
    lci_kw_t    kw;
    lci_op_t    op;
  } lci_cmd_t;
  // Measurement snapshot
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] i;
    logic [31:0] p;
  } lci_meas_t;
  // Adjustment limits from the setup menu
  typedef struct packed {
    logic        en;
    logic [31:0] loV;
    logic [31:0] hiV;
    logic [31:0] loI;
    logic [31:0] hiI;
    logic [31:0] hiP;
    logic [31:0] hiR;
  } lci_lim_t;
  // STATUS register layout, bit 31 downward
  typedef struct packed {
    logic [19:0] zero;
    logic        stbErr;
    logic [2:0]  resCnt;
    logic [2:0]  errCnt;
    logic        quesAlarm;
    logic        inOn;
    lci_own_t    owner;
    logic        busy;
  } lci_sts_t;
endpackage : lci_pkg
`default_nettype wire

// ===== verilog/lci_sync.sv
// Two-flop synchroniser for asynchronous pins.
// Assumes the inputs are quasi-static levels.
`timescale 1ns/1ps
`default_nettype none
module lci_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } lci_sync_st_t;
  lci_sync_st_t s_q, s_d;

  // First stage feeds only the second
  always_comb begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.out  = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.out;
endmodule : lci_sync
`default_nettype wire

// ===== verilog/lci_fifo.sv
// Small FIFO memory holding queued command error codes.
// Read data is registered: a pop shows its word one cycle later.
`timescale 1ns/1ps
`default_nettype none
module lci_fifo #(
  parameter int W = 16,
  parameter int D = 5
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   push,
  input  wire logic [W-1:0]           wdata,
  input  wire logic                   pop,
  input  wire logic                   flush,
  output logic      [W-1:0]           rdata,
  output logic      [$clog2(D+1)-1:0] count
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D+1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [CW-1:0]       cnt;
    logic [W-1:0]        rd;
  } lci_fifo_st_t;
  lci_fifo_st_t s_q, s_d;
  logic         doWr, doRd;

  // Full drops new codes, empty ignores pops
  always_comb begin
    s_d  = s_q;
    doWr = push && (s_q.cnt != CW'(D));
    doRd = pop && (s_q.cnt != '0);
    if (flush) begin
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end else begin
      if (doWr) begin
        s_d.mem[s_q.wp] = wdata;
        s_d.wp = (s_q.wp == PW'(D-1)) ? '0 : s_q.wp + 1'b1;
      end
      if (doRd) begin
        s_d.rd = s_q.mem[s_q.rp];
        s_d.rp = (s_q.rp == PW'(D-1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + CW'(doWr) - CW'(doRd);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rd;
  assign count = s_q.cnt;
endmodule : lci_fifo
`default_nettype wire

// ===== verilog/lci_top.sv
// Remote command interpreter of an electronic DC load, AHB-Lite slave.
// Assumes pre-parsed commands written to CMD/PARAM, one 10 MHz clock,
// measurement and limit inputs from logic on the same clock.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lci_top
  import lci_pkg::*;
#(
  parameter logic [31:0] NOM_V     = 32'h50,
  parameter logic [31:0] NOM_I     = 32'hAA,
  parameter logic [31:0] NOM_P     = 32'h1388,
  parameter logic [31:0] R_MIN     = 32'h1,
  parameter logic [31:0] R_MAX     = 32'h2710,
  parameter int          ERR_DEPTH = ERRQ_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        localKey,
  input  wire logic        alarmIn,
  input  wire lci_meas_t   meas,
  input  wire logic        measValid,
  input  wire lci_lim_t    lim,
  output logic             dcInputOn,
  output logic             remoteActive,
  output logic      [31:0] vTarget,
  output logic      [31:0] iSetOut,
  output logic      [31:0] pSetOut,
  output logic      [31:0] rSetOut
);
  localparam int CW = $clog2(ERR_DEPTH+1);
  localparam logic [47:0] HI_NOM_V = 48'(NOM_V) * 48'(PCT_SET) / 48'(PCT_DEN);
  localparam logic [47:0] HI_NOM_I = 48'(NOM_I) * 48'(PCT_SET) / 48'(PCT_DEN);
  localparam logic [47:0] HI_NOM_P = 48'(NOM_P) * 48'(PCT_SET) / 48'(PCT_DEN);
  localparam logic [47:0] CAP_V    = 48'(NOM_V) * 48'(PCT_MEAS) / 48'(PCT_DEN);
  localparam logic [47:0] CAP_I    = 48'(NOM_I) * 48'(PCT_MEAS) / 48'(PCT_DEN);
  localparam logic [47:0] CAP_P    = 48'(NOM_P) * 48'(PCT_MEAS) / 48'(PCT_DEN);

  typedef struct packed {
    lci_st_t                  st;
    logic                     go;
    logic                     all;
    lci_cmd_t                 cmd;
    logic [31:0]              param;
    logic                     irMode;
    logic                     wrPend;
    logic [7:0]               wrAddr;
    logic [31:0]              hrdata;
    logic                     rdy;
    lci_own_t                 owner;
    logic [1:0]               ownIf;
    logic                     inOn;
    logic                     quesAlarm;
    logic [31:0]              vSet;
    logic [31:0]              iSet;
    logic [31:0]              pSet;
    logic [31:0]              rSet;
    logic [31:0]              vTgt;
    logic [15:0]              operEn;
    lci_meas_t                snap;
    logic [ERR_DEPTH-1:0][31:0] res;
    logic [CW-1:0]            resCnt;
  } lci_top_st_t;

  lci_top_st_t   s_q, s_d;
  logic          localSync, alarmSync;
  logic          push, pop, flush, exec, isOwner, inRange, errRead;
  logic [15:0]   pushCode, ownCode, fifoRd;
  logic [CW-1:0] fifoCnt;
  logic [47:0]   val, lo, hi;
  logic [31:0]   newVal, rdMux;
  logic [63:0]   drop;
  lci_sts_t      sts;

  // Front-panel key and alarm come from pins
  lci_sync #(.W(2)) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({localKey, alarmIn}),
    .q     ({localSync, alarmSync})
  );

  // Only command errors are ever pushed here, alarms never
  lci_fifo #(.W(16), .D(ERR_DEPTH)) uErrQ (
    .clk   (clk),
    .rst_n (rst_n),
    .push  (push),
    .wdata (pushCode),
    .pop   (pop),
    .flush (flush),
    .rdata (fifoRd),
    .count (fifoCnt)
  );

  // Command decode helpers
  always_comb begin
    exec    = (s_q.st == ST_IDLE) && s_q.go;
    isOwner = (s_q.owner == OWN_REMOTE) && (s_q.ownIf == s_q.cmd.ifId);
    ownCode = (s_q.owner == OWN_LOCAL) ? ERR_LOCAL : ERR_EXEC;
    val     = s_q.cmd.kilo ? 48'(s_q.param) * 48'(KILO) : 48'(s_q.param);
    lo      = '0;
    hi      = '0;
    case (s_q.cmd.op)
      OP_SET_V: begin
        lo = lim.en ? 48'(lim.loV) : '0;
        hi = lim.en ? 48'(lim.hiV) : HI_NOM_V;
      end
      OP_SET_I: begin
        lo = lim.en ? 48'(lim.loI) : '0;
        hi = lim.en ? 48'(lim.hiI) : HI_NOM_I;
      end
      OP_SET_P: begin
        hi = lim.en ? 48'(lim.hiP) : HI_NOM_P;
      end
      OP_SET_R: begin
        lo = 48'(R_MIN);
        hi = (lim.en && lim.hiR < R_MAX) ? 48'(lim.hiR) : 48'(R_MAX);
      end
      default: begin
        lo = '0;
      end
    endcase
    // Keywords bypass the range check and pick a bound
    inRange = (s_q.cmd.kw != KW_NUM) || (val >= lo && val <= hi);
    newVal  = (s_q.cmd.kw == KW_MIN) ? lo[31:0] :
              (s_q.cmd.kw == KW_MAX) ? hi[31:0] : val[31:0];
    // Series drop for resistance mode, clamped at zero
    drop    = (64'(s_q.rSet) * 64'(s_q.snap.i)) / 64'(R_SCALE);
  end

  // Status word and register read mux
  always_comb begin
    sts           = '0;
    sts.busy      = (s_q.st != ST_IDLE) || s_q.go;
    sts.owner     = s_q.owner;
    sts.inOn      = s_q.inOn;
    sts.quesAlarm = s_q.quesAlarm;
    sts.errCnt    = 3'(fifoCnt);
    sts.resCnt    = 3'(s_q.resCnt);
    sts.stbErr    = (fifoCnt != '0);
    rdMux         = '0;
    if (haddr[7:0] == ADDR_CMD) begin
      rdMux = 32'(s_q.cmd);
    end else if (haddr[7:0] == ADDR_PARAM) begin
      rdMux = s_q.param;
    end else if (haddr[7:0] == ADDR_CFG) begin
      rdMux = 32'(s_q.irMode);
    end else if (haddr[7:0] == ADDR_STATUS) begin
      rdMux = sts;
    end else begin
      for (int k = 0; k < ERR_DEPTH; k++) begin
        if (haddr[7:0] == ADDR_RES0 + 8'(4 * k)) rdMux = s_q.res[k];
      end
    end
  end

  // Next state: bus, command execution, queue drain, pins
  always_comb begin
    s_d      = s_q;
    push     = 1'b0;
    pushCode = ERR_NONE;
    pop      = 1'b0;
    flush    = 1'b0;
    errRead  = 1'b0;
    s_d.rdy  = 1'b1;
    // Data phase of a write; CMD ignored while busy
    if (s_q.wrPend) begin
      if (s_q.wrAddr == ADDR_CMD) begin
        if (s_q.st == ST_IDLE && !s_q.go) begin
          s_d.cmd = lci_cmd_t'(hwdata[9:0]);
          s_d.go  = 1'b1;
        end
      end else if (s_q.wrAddr == ADDR_PARAM) begin
        s_d.param = hwdata;
      end else if (s_q.wrAddr == ADDR_CFG) begin
        s_d.irMode = hwdata[0];
      end
    end
    // Address phase; zero wait states, unmapped reads give zero
    s_d.wrPend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_d.wrPend = hwrite;
      s_d.wrAddr = haddr[7:0];
      if (!hwrite) s_d.hrdata = rdMux;
    end
    if (exec) begin
      s_d.go = 1'b0;
      case (s_q.cmd.op)
        OP_SET_V, OP_SET_I, OP_SET_P, OP_SET_R: begin
          if (!isOwner) begin
            push     = 1'b1;
            pushCode = ownCode;
          end else if (!inRange) begin
            push     = 1'b1;
            pushCode = ERR_RANGE;
          end else if (s_q.cmd.op == OP_SET_V) begin
            s_d.vSet = newVal;
          end else if (s_q.cmd.op == OP_SET_I) begin
            s_d.iSet = newVal;
          end else if (s_q.cmd.op == OP_SET_P) begin
            s_d.pSet = newVal;
          end else begin
            s_d.rSet = newVal;
          end
        end
        OP_Q_V, OP_Q_I, OP_Q_P, OP_Q_R: begin
          s_d.resCnt = CW'(1);
          s_d.res[0] = (s_q.cmd.op == OP_Q_V) ? s_q.vSet :
                       (s_q.cmd.op == OP_Q_I) ? s_q.iSet :
                       (s_q.cmd.op == OP_Q_P) ? s_q.pSet : s_q.rSet;
        end
        OP_MEAS_V, OP_MEAS_I, OP_MEAS_P: begin
          s_d.resCnt = CW'(1);
          s_d.res[0] = (s_q.cmd.op == OP_MEAS_V) ? s_q.snap.v :
                       (s_q.cmd.op == OP_MEAS_I) ? s_q.snap.i : s_q.snap.p;
        end
        OP_COMBINED_MEASUREMENT_QUERY: begin
          s_d.resCnt = CW'(3);
          s_d.res[0] = s_q.snap.v;
          s_d.res[1] = s_q.snap.i;
          s_d.res[2] = s_q.snap.p;
        end
        OP_LOCK: begin
          if (!s_q.param[0]) begin
            if (isOwner) s_d.owner = OWN_NONE;
          end else if (s_q.owner == OWN_LOCAL) begin
            push     = 1'b1;
            pushCode = ERR_LOCAL;
          end else if (s_q.owner == OWN_REMOTE && !isOwner) begin
            push     = 1'b1;
            pushCode = ERR_EXEC;
          end else begin
            s_d.owner = OWN_REMOTE;
            s_d.ownIf = s_q.cmd.ifId;
          end
        end
        OP_Q_OWNER: begin
          s_d.resCnt = CW'(1);
          s_d.res[0] = 32'(s_q.owner);
        end
        OP_INPUT: begin
          if (!isOwner) begin
            push     = 1'b1;
            pushCode = ownCode;
          end else begin
            s_d.inOn = s_q.param[0];
          end
        end
        OP_Q_INPUT: begin
          s_d.resCnt = CW'(1);
          s_d.res[0] = 32'(s_q.inOn);
        end
        OP_ERR_NEXT, OP_ERR_ALL: begin
          errRead = 1'b1;
          if (fifoCnt == '0) begin
            s_d.resCnt = CW'(1);
            s_d.res[0] = '0;
          end else begin
            pop        = 1'b1;
            s_d.resCnt = '0;
            s_d.all    = (s_q.cmd.op == OP_ERR_ALL);
            s_d.st     = ST_CAP;
          end
        end
        OP_CLS: begin
          flush         = 1'b1;
          s_d.quesAlarm = 1'b0;
        end
        OP_OPER_EN: begin
          if (s_q.param == '0 || (s_q.param >= 32'(OPER_EN_LO) &&
                                  s_q.param <= 32'(OPER_EN_HI))) begin
            s_d.operEn = s_q.param[15:0];
          end else begin
            push     = 1'b1;
            pushCode = ERR_RANGE;
          end
        end
        OP_Q_OPER_EN: begin
          s_d.resCnt = CW'(1);
          s_d.res[0] = 32'(s_q.operEn);
        end
        OP_NOP: begin
          s_d.go = 1'b0;
        end
        default: begin
          push     = 1'b1;
          pushCode = ERR_CMD;
        end
      endcase
    end
    // Registered queue word arrives; read-all keeps popping
    if (s_q.st == ST_CAP) begin
      s_d.res[s_q.resCnt] = {{16{fifoRd[15]}}, fifoRd};
      s_d.resCnt          = s_q.resCnt + 1'b1;
      if (s_q.all && fifoCnt != '0) begin
        pop = 1'b1;
      end else begin
        s_d.st = ST_IDLE;
      end
    end
    // Error read acknowledges alarms that are gone; a live one stays
    if (errRead && !alarmSync) s_d.quesAlarm = 1'b0;
    if (alarmSync) begin
      s_d.quesAlarm = 1'b1;
      s_d.inOn      = 1'b0;
    end
    // Local mode overrides any remote grant
    if (localSync) begin
      s_d.owner = OWN_LOCAL;
    end else if (s_q.owner == OWN_LOCAL) begin
      s_d.owner = OWN_NONE;
    end
    // Snapshot clamped to the reportable span
    if (measValid) begin
      s_d.snap.v = (48'(meas.v) > CAP_V) ? CAP_V[31:0] : meas.v;
      s_d.snap.i = (48'(meas.i) > CAP_I) ? CAP_I[31:0] : meas.i;
      s_d.snap.p = (48'(meas.p) > CAP_P) ? CAP_P[31:0] : meas.p;
    end
    // Regulated voltage target
    if (!s_q.irMode) begin
      s_d.vTgt = s_q.vSet;
    end else if (drop >= 64'(s_q.vSet)) begin
      s_d.vTgt = '0;
    end else begin
      s_d.vTgt = s_q.vSet - drop[31:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q        <= '0;
      s_q.rdy    <= 1'b1;
      s_q.operEn <= OPER_EN_RST;
      s_q.rSet   <= R_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign hreadyout    = s_q.rdy;
  assign hresp        = 1'b0 & s_q.rdy;
  assign hrdata       = s_q.hrdata;
  assign dcInputOn    = s_q.inOn;
  assign remoteActive = s_q.owner[0]; // Only the remote code has bit 0 set
  assign vTarget      = s_q.vTgt;
  assign iSetOut      = s_q.iSet;
  assign pSetOut      = s_q.pSet;
  assign rSetOut      = s_q.rSet;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_OPER_RANGE: assert property (
    s_q.operEn == 16'h0 || (s_q.operEn >= OPER_EN_LO && s_q.operEn <= OPER_EN_HI))
    else $error("operation enable filter holds an illegal value");
  AST_RANGE_KEEP: assert property (
    exec && s_q.cmd.op == OP_SET_V && isOwner && !inRange
    |-> push && pushCode == ERR_RANGE ##1 s_q.vSet == $past(s_q.vSet))
    else $error("out-of-range voltage applied or not reported");
  AST_NEED_REMOTE: assert property (
    exec && s_q.cmd.op == OP_SET_I && !isOwner |=> $stable(s_q.iSet))
    else $error("current changed without remote ownership");
  AST_INPUT_LOCKED: assert property (
    exec && s_q.cmd.op == OP_INPUT && !isOwner |=> !$rose(s_q.inOn))
    else $error("input switched without remote control");
  AST_ALARM_OFF: assert property (
    alarmSync |=> !s_q.inOn && s_q.quesAlarm)
    else $error("alarm did not force the input off");
  AST_LOCAL_OWN: assert property (
    localSync |=> s_q.owner == OWN_LOCAL)
    else $error("local mode did not take ownership");
  AST_LOCK_REFUSE: assert property (
    exec && s_q.cmd.op == OP_LOCK && s_q.param[0] && s_q.owner == OWN_LOCAL
    |-> push && pushCode == ERR_LOCAL)
    else $error("refused lock request queued no error");
  AST_ERR_EMPTY: assert property (
    exec && s_q.cmd.op == OP_ERR_NEXT && fifoCnt == '0
    |=> s_q.res[0] == 32'h0 && s_q.resCnt == CW'(1))
    else $error("empty queue did not answer code zero");
  AST_ALL_DRAIN: assert property (
    exec && s_q.cmd.op == OP_ERR_ALL && fifoCnt != '0
    |-> ##[2:7] (s_q.st == ST_IDLE && fifoCnt == '0))
    else $error("read-all did not empty the queue");
  AST_MEAS_CAP: assert property (
    48'(s_q.snap.v) <= CAP_V && 48'(s_q.snap.p) <= CAP_P)
    else $error("snapshot above reportable span");
endmodule : lci_top
`default_nettype wire

// ===== verif/lci_host.sv
// Host model: AHB-Lite master issuing single word transfers.
// Assumes the one slave's hreadyout comes back as hready.
`timescale 1ns/1ps
`default_nettype none
module lci_host (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata,
  output logic             hung
);
  // Bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    r = hrdata;
    // Select stays up; htrans IDLE ends the transfer, so a following call
    // never assigns hsel twice in one time step
    // Released data must not keep its last value
    hwdata <= ~hwdata;
    // Blocking, so the caller sees a hang in this same time step
    hung = (n >= 40);
  endtask : xfer
endmodule : lci_host
`default_nettype wire

// ===== verif/lci_top_tb.sv
// Self-checking bench of the command interpreter.
// Assumes lci_host as bus master and same-clock pins and snapshots.
`timescale 1ns/1ps
`default_nettype none
module lci_top_tb;
  import lci_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        localKey = 1'b0;
  logic        alarmIn = 1'b0;
  logic        measValid = 1'b0;
  lci_meas_t   meas = '0;
  lci_lim_t    lim = '0;
  logic        hsel, hwrite, hreadyout, hresp, hung, dcInputOn, remoteActive;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, vTarget, iSetOut, pSetOut, rSetOut, rv;
  int          err_count = 0;
  int          total_checks = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  lci_host host_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hung(hung));
  lci_top dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .localKey(localKey), .alarmIn(alarmIn), .meas(meas), .measValid(measValid),
    .lim(lim), .dcInputOn(dcInputOn), .remoteActive(remoteActive),
    .vTarget(vTarget), .iSetOut(iSetOut), .pSetOut(pSetOut), .rSetOut(rSetOut));
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(w, a, d, rv);
    if (hung === 1'b1) begin
      err_count++;
      finish_test();
    end
  endtask : bus
  // PARAM then CMD, then poll busy under a bound
  task automatic cmd(input lci_op_t op, input lci_kw_t kw, input logic k,
                     input logic [31:0] p, input logic [1:0] ifc = 2'h0);
    lci_cmd_t c;
    c = '{ifId: ifc, kilo: k, kw: kw, op: op};
    bus(1'b1, ADDR_PARAM, p);
    bus(1'b1, ADDR_CMD, {22'h0, c});
    for (int n = 0; n < 20; n++) begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      if (rv[0] === 1'b0)
        return;
    end
    err_count++;
    finish_test();
  endtask : cmd
  task automatic res(input lci_op_t op, input logic [31:0] e);
    cmd(op, KW_NUM, 1'b0, 32'h0);
    bus(1'b0, ADDR_RES0, 32'h0);
    chk(op.name(), e, rv);
  endtask : res
  // Refusals without lock, then ownership by one interface
  task automatic s_lock;
    cmd(OP_SET_V, KW_NUM, 1'b0, 32'hA);
    res(OP_ERR_NEXT, 32'hFFFFFF38);
    res(OP_ERR_NEXT, 32'h0);
    res(OP_ERR_NEXT, 32'h0);
    cmd(OP_LOCK, KW_NUM, 1'b0, 32'h1);
    chk("remote", 32'h1, {31'h0, remoteActive});
    cmd(OP_LOCK, KW_NUM, 1'b0, 32'h1, 2'h1);
    cmd(OP_SET_V, KW_NUM, 1'b0, 32'hA, 2'h1);
    chk("owner", 32'h1, {30'h0, rv[2:1]});
    res(OP_ERR_NEXT, 32'hFFFFFF38);
    res(OP_ERR_NEXT, 32'hFFFFFF38);
    res(OP_Q_V, 32'h0);
  endtask : s_lock
  // Limits, keywords, kilo prefix and setting queries
  task automatic s_set;
    cmd(OP_SET_V, KW_NUM, 1'b0, 32'h51);
    res(OP_Q_V, 32'h51);
    cmd(OP_SET_V, KW_NUM, 1'b0, 32'h52);
    res(OP_ERR_NEXT, 32'hFFFFFF22);
    res(OP_Q_V, 32'h51);
    cmd(OP_SET_P, KW_NUM, 1'b1, 32'h5);
    chk("pSet", 32'h1388, pSetOut);
    cmd(OP_SET_P, KW_MIN, 1'b0, 32'h0);
    res(OP_Q_P, 32'h0);
    lim <= '{en: 1'b1, hiI: 32'h64, hiV: 32'h51, hiP: 32'h1388, hiR: 32'h2710,
             default: 32'h0};
    cmd(OP_SET_I, KW_MAX, 1'b0, 32'h0);
    chk("iSet", 32'h64, iSetOut);
    lim <= '0;
    cmd(OP_SET_R, KW_MAX, 1'b0, 32'h0);
    chk("rSet", 32'h2710, rSetOut);
  endtask : s_set
  // Input switching and alarm-forced off
  task automatic s_input;
    cmd(OP_INPUT, KW_NUM, 1'b0, 32'h1);
    chk("inOn", 32'h1, {31'h0, dcInputOn});
    alarmIn <= 1'b1;
    repeat (4) @(posedge clk);
    res(OP_Q_INPUT, 32'h0);
    // A live alarm survives an error read, a gone one is acknowledged
    cmd(OP_ERR_NEXT, KW_NUM, 1'b0, 32'h0);
    chk("quesAlarm", 32'h1, {31'h0, rv[4]});
    alarmIn <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(OP_ERR_NEXT, KW_NUM, 1'b0, 32'h0);
    chk("quesAlarm", 32'h0, {31'h0, rv[4]});
  endtask : s_input
  // Snapshot captured, array answers in V, I, P order
  task automatic s_meas;
    meas <= '{v: 32'hA, i: 32'h14, p: 32'h1E};
    measValid <= 1'b1;
    @(posedge clk);
    measValid <= 1'b0;
    cmd(OP_COMBINED_MEASUREMENT_QUERY, KW_NUM, 1'b0, 32'h0);
    for (int n = 0; n < 3; n++) begin
      bus(1'b0, ADDR_RES0 + 8'(4 * n), 32'h0);
      chk("arr", 32'hA * (n + 1), rv);
    end
    // Series drop 1000 * 20 / R_SCALE takes 81 down to 61
    bus(1'b1, ADDR_CFG, 32'h1);
    cmd(OP_SET_R, KW_NUM, 1'b0, 32'h3E8);
    chk("vTarget", 32'h3D, vTarget);
  endtask : s_meas
  // Local key takes over, control then refused
  task automatic s_local;
    localKey <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(OP_SET_V, KW_NUM, 1'b0, 32'h5);
    chk("owner", 32'h2, {30'h0, rv[2:1]});
    res(OP_ERR_NEXT, 32'hFFFFFF37);
    cmd(OP_LOCK, KW_NUM, 1'b0, 32'h1);
    res(OP_ERR_NEXT, 32'hFFFFFF37);
    cmd(OP_SET_I, KW_NUM, 1'b0, 32'h5);
    chk("iSet", 32'h64, iSetOut);
    res(OP_ERR_NEXT, 32'hFFFFFF37);
    localKey <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : s_local
  // Queue overflow, read-all, clear-status
  task automatic s_queue;
    for (int n = 0; n < 6; n++)
      cmd(lci_op_t'(5'h1F), KW_NUM, 1'b0, 32'h0);
    res(OP_ERR_ALL, 32'hFFFFFF9C);
    bus(1'b0, ADDR_RES0 + 8'h10, 32'h0);
    chk("res4", 32'hFFFFFF9C, rv);
    // Counts live in STATUS, not in the result words
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("resCnt", 32'h5, {29'h0, rv[10:8]});
    chk("errCnt", 32'h0, {29'h0, rv[7:5]});
    cmd(lci_op_t'(5'h1F), KW_NUM, 1'b0, 32'h0);
    cmd(OP_CLS, KW_NUM, 1'b0, 32'h0);
    res(OP_ERR_NEXT, 32'h0);
  endtask : s_queue
  // Reset, then scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_lock();
    s_set();
    s_input();
    s_meas();
    s_local();
    s_queue();
    finish_test();
  end
endmodule : lci_top_tb
`default_nettype wire
